// File: include/ddr_sram_cfg.svh
`ifndef DDR_SRAM_CFG_SVH
`define DDR_SRAM_CFG_SVH

// Lane geometry: one byte lane carries a 9-bit beat, two beats form a protected word
`define LANE_W          9
`define WORD_W          18
`define CHK_W           5
`define CODE_W          23

// Default array geometry and write buffer depth
`define ADDR_W_DEF      8
`define LANES_DEF       2
`define WBUF_DEPTH_DEF  16

// Power-up waits in input clock cycles; the bench controller waits WAKE_CYC edges instead
`define IMPEDANCE_SETUP_CYC 163840
`define DLL_LOCK_CYC    65536

`endif

// File: include/ddr_sram_pkg.sv
package ddr_sram_pkg;
	// Each system edge is one half of a device cycle
	typedef enum logic {
		PH_K  = 1'b0,
		PH_KN = 1'b1
	} phase_e;
endpackage

// File: rtl/ddr_wbuf_fifo.sv
`timescale 1ns/100ps
module ddr_wbuf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys_i,  // System clock
	input  wire logic             sys_rst_i,  // Async reset, active high
	input  wire logic             in_valid_i, // Push request
	output logic                  in_ready_o, // Not full
	input  wire logic [WIDTH-1:0] in_data_i,  // Push data
	output logic                  out_valid_o,// Not empty
	input  wire logic             out_ready_i,// Pop request
	output logic      [WIDTH-1:0] out_data_o  // Head word
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    rd_ptr;
	logic [PW-1:0]    wr_ptr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count < (PW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = store[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;

	always_comb begin
		next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = count;
		if (push && !pop) begin
			next_count = (PW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (PW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count  <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count  <= next_count;
		end
	end

	// Storage needs no reset; count guards every read
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			store[wr_ptr] <= in_data_i;
		end
	end
endmodule

// File: rtl/ddr_sram_port_ecc.sv
`timescale 1ns/100ps
`include "ddr_sram_cfg.svh"
//
// Contract
// - Read port captures address and read request on every primary clock rise.
// - Low read request starts a read; high gives an idle read-port cycle.
// - Read data leaves in two beats, first after an inverted rise, second after the next primary rise.
// - Write request taken on primary rise, write address on following inverted rise.
// - Low write request starts a write; high gives an idle cycle storing nothing.
// - First data beat with the request, second beat with the address.
// - Each byte enable is sampled with the data beat it qualifies.
// - High byte enable blocks storing that byte; old contents stay unchanged.
// - Enable 0 covers bits 8..0, enable 1 bits 17..9, further lanes likewise.
// - One write request and address fill one location with two beats.
// - Per lane enable pair selects both, first only, second only, or none.
// - Any half write turns error correction off until power is removed.
// - Each two-beat lane word carries five hidden Hamming check bits.
// - Multi-bit errors may pass uncorrected and without any indication.
// - Low timing-loop disable input runs the device with its loop off.
// - Read beats appear 2.5 and 3 cycles after the read is sampled.
// - Idle or write slots drive outputs low or off for one cycle.
module ddr_sram_port_ecc #(
	parameter int ADDR_W = `ADDR_W_DEF,
	parameter int LANES  = `LANES_DEF,
	parameter int WBUF_D = `WBUF_DEPTH_DEF
) (
	input  wire logic                      clk_sys_i,             // 40 MHz clock
	input  wire logic                      sys_rst_i,             // Async reset
	input  wire logic [ADDR_W-1:0]         address_bus_i,         // Shared address pins
	input  wire logic                      read_req_n_i,          // Read request, low
	input  wire logic                      write_req_n_i,         // Write request, low
	input  wire logic [LANES*`LANE_W-1:0]  write_data_in_i,       // Write data beats
	input  wire logic [LANES-1:0]          byte_lane_enables_n_i, // Lane enables, low
	input  wire logic                      termination_select_i,  // Termination on
	input  wire logic                      dll_disable_n_i,       // Loop off when low
	output logic      [LANES*`LANE_W-1:0]  read_data_out_o,       // Read data beats
	output logic                           read_data_oe_o,        // Output driver on
	output logic                           read_valid_flag_o,     // Beat is read data
	output logic                           echo_timing_output_o,  // Half-cycle echo
	output logic                           write_ready_o,         // Write buffer room
	output logic                           ecc_active_o,          // Correction enabled
	output logic                           dll_active_o           // Timing loop running
);
	localparam int DW    = LANES * `LANE_W;
	localparam int SW    = ADDR_W + DW + LANES + 4;
	localparam int BW    = ADDR_W + 2 * LANES + 2 * DW;
	localparam int DEPTH = 1 << ADDR_W;

	//////////////////////////////////////////////////////////////////////////////
	// Hamming code over one lane word
	function automatic logic [`CHK_W-1:0] hm_chk(input logic [`WORD_W-1:0] d);
		logic [`CHK_W-1:0] c;
		int                k;
		c = '0;
		k = 0;
		for (int p = 1; p <= `CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int i = 0; i < `CHK_W; i++) begin
					if (p[i]) begin
						c[i] = c[i] ^ d[k];
					end
				end
				k++;
			end
		end
		return c;
	endfunction

	// Only a syndrome that names one data position flips a bit; others pass as is
	function automatic logic [`WORD_W-1:0] hm_fix(input logic [`WORD_W-1:0] d,
			input logic [`CHK_W-1:0] c);
		logic [`WORD_W-1:0] o;
		logic [`CHK_W-1:0]  syn;
		int                 k;
		o   = d;
		syn = hm_chk(d) ^ c;
		k   = 0;
		for (int p = 1; p <= `CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (syn == p[`CHK_W-1:0]) begin
					o[k] = ~o[k];
				end
				k++;
			end
		end
		return o;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [SW-1:0]         sync1;
	logic [SW-1:0]         sync2;
	logic [ADDR_W-1:0]     addr_s;
	logic                  rd_n_s;
	logic                  wr_n_s;
	logic [DW-1:0]         data_s;
	logic [LANES-1:0]      bw_n_s;
	logic                  term_s;
	logic                  dll_n_s;

	// Requests and enables reset to their idle high level, so no phantom command follows reset
	localparam logic [SW-1:0] SYNC_IDLE = {ADDR_W'(0), 2'b11, DW'(0), {LANES{1'b1}}, 2'b01};

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end else begin
			sync1 <= {address_bus_i, read_req_n_i, write_req_n_i, write_data_in_i,
				byte_lane_enables_n_i, termination_select_i, dll_disable_n_i};
			sync2 <= sync1;
		end
	end

	assign {addr_s, rd_n_s, wr_n_s, data_s, bw_n_s, term_s, dll_n_s} = sync2;

	//////////////////////////////////////////////////////////////////////////////
	// Command capture and write buffer
	ddr_sram_pkg::phase_e  ph;
	ddr_sram_pkg::phase_e  next_ph;
	logic                  rd_cmd;
	logic                  wr_pend;
	logic                  next_wr_pend;
	logic [DW-1:0]         wd0;
	logic [DW-1:0]         next_wd0;
	logic [LANES-1:0]      wm0;
	logic [LANES-1:0]      next_wm0;
	logic                  push_v;
	logic [BW-1:0]         push_w;
	logic                  buf_ready;
	logic                  buf_valid;
	logic [BW-1:0]         buf_w;
	logic                  drain;
	logic [ADDR_W-1:0]     w_addr;
	logic [LANES-1:0]      w_m1;
	logic [LANES-1:0]      w_m0;
	logic [DW-1:0]         w_d1;
	logic [DW-1:0]         w_d0;
	logic                  half_wr;

	assign rd_cmd = (ph == ddr_sram_pkg::PH_K) && !rd_n_s;
	assign push_v = (ph == ddr_sram_pkg::PH_KN) && wr_pend;
	assign push_w = {addr_s, bw_n_s, wm0, data_s, wd0};
	// Reads own the array on their slot; writes wait in the buffer behind them
	assign drain  = buf_valid && (ph == ddr_sram_pkg::PH_K) && !rd_cmd;
	assign {w_addr, w_m1, w_m0, w_d1, w_d0} = buf_w;
	assign half_wr = drain && ((w_m0 ^ w_m1) != '0);

	always_comb begin
		next_ph      = (ph == ddr_sram_pkg::PH_K) ? ddr_sram_pkg::PH_KN : ddr_sram_pkg::PH_K;
		next_wr_pend = 1'b0;
		next_wd0     = wd0;
		next_wm0     = wm0;
		if (ph == ddr_sram_pkg::PH_K) begin
			next_wr_pend = !wr_n_s;
			if (!wr_n_s) begin
				next_wd0 = data_s;
				next_wm0 = bw_n_s;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ph      <= ddr_sram_pkg::PH_K;
			wr_pend <= 1'b0;
			wd0     <= '0;
			wm0     <= '1;
		end else begin
			ph      <= next_ph;
			wr_pend <= next_wr_pend;
			wd0     <= next_wd0;
			wm0     <= next_wm0;
		end
	end

	ddr_wbuf_fifo #(
		.WIDTH (BW),
		.DEPTH (WBUF_D)
	) u_wbuf (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (push_v),
		.in_ready_o  (buf_ready),
		.in_data_i   (push_w),
		.out_valid_o (buf_valid),
		.out_ready_i (drain),
		.out_data_o  (buf_w)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Lane arrays
	logic                  ecc_on;
	logic [LANES*`WORD_W-1:0] corr;

	genvar l;
	generate
		for (l = 0; l < LANES; l++) begin : g_lane
			logic [`LANE_W-1:0] mem_b0 [DEPTH];
			logic [`LANE_W-1:0] mem_b1 [DEPTH];
			logic [`CHK_W-1:0]  mem_ck [DEPTH];
			logic [`LANE_W-1:0] raw_b0;
			logic [`LANE_W-1:0] raw_b1;
			logic [`CHK_W-1:0]  raw_ck;
			logic [`LANE_W-1:0] d0;
			logic [`LANE_W-1:0] d1;

			assign d0 = w_d0[l*`LANE_W +: `LANE_W];
			assign d1 = w_d1[l*`LANE_W +: `LANE_W];

			always_ff @(posedge clk_sys_i) begin
				if (drain && !w_m0[l]) begin
					mem_b0[w_addr] <= d0;
				end
				if (drain && !w_m1[l]) begin
					mem_b1[w_addr] <= d1;
				end
				// Check bits only make sense for a full word; a half write ends correction
				if (drain && !w_m0[l] && !w_m1[l]) begin
					mem_ck[w_addr] <= hm_chk({d1, d0});
				end
				if (rd_cmd) begin
					raw_b0 <= mem_b0[addr_s];
					raw_b1 <= mem_b1[addr_s];
					raw_ck <= mem_ck[addr_s];
				end
			end

			// Double errors are not flagged and may come out miscorrected
			assign corr[l*`WORD_W +: `WORD_W] = ecc_on ?
				hm_fix({raw_b1, raw_b0}, raw_ck) : {raw_b1, raw_b0};
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// Read pipeline and output drivers
	logic                  f1;
	logic                  fa;
	logic                  fb;
	logic [LANES*`WORD_W-1:0] rw1;
	logic [LANES*`WORD_W-1:0] wa;
	logic [LANES*`WORD_W-1:0] wb;
	logic [DW-1:0]         beat0;
	logic [DW-1:0]         beat1;
	logic                  next_f1;
	logic                  next_fa;
	logic                  next_fb;
	logic [LANES*`WORD_W-1:0] next_rw1;
	logic [LANES*`WORD_W-1:0] next_wa;
	logic [LANES*`WORD_W-1:0] next_wb;
	logic [DW-1:0]         next_q;
	logic                  next_oe;
	logic                  next_vld;
	logic                  next_off;
	logic                  ecc_off;

	assign ecc_on = !ecc_off;

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			beat0[i*`LANE_W +: `LANE_W] = wb[i*`WORD_W +: `LANE_W];
			beat1[i*`LANE_W +: `LANE_W] = wb[i*`WORD_W + `LANE_W +: `LANE_W];
		end
	end

	always_comb begin
		next_f1  = f1;
		next_fa  = fa;
		next_fb  = fb;
		next_rw1 = rw1;
		next_wa  = wa;
		next_wb  = wb;
		if (ph == ddr_sram_pkg::PH_K) begin
			next_f1 = rd_cmd;
			next_fa = f1;
			next_wa = rw1;
			next_fb = fa;
			next_wb = wa;
		end else begin
			next_rw1 = corr;
		end
		// Beat 0 on the inverted half, beat 1 on the following primary half
		next_vld = fb;
		next_q   = '0;
		next_oe  = term_s;
		if (fb) begin
			next_q  = (ph == ddr_sram_pkg::PH_KN) ? beat0 : beat1;
			next_oe = 1'b1;
		end
		next_off = ecc_off || half_wr;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			f1                   <= 1'b0;
			fa                   <= 1'b0;
			fb                   <= 1'b0;
			rw1                  <= '0;
			wa                   <= '0;
			wb                   <= '0;
			read_data_out_o      <= '0;
			read_data_oe_o       <= 1'b0;
			read_valid_flag_o    <= 1'b0;
			echo_timing_output_o <= 1'b0;
			write_ready_o        <= 1'b0;
			ecc_active_o         <= 1'b0;
			dll_active_o         <= 1'b0;
			ecc_off              <= 1'b0;
		end else begin
			f1                   <= next_f1;
			fa                   <= next_fa;
			fb                   <= next_fb;
			rw1                  <= next_rw1;
			wa                   <= next_wa;
			wb                   <= next_wb;
			read_data_out_o      <= next_q;
			read_data_oe_o       <= next_oe;
			read_valid_flag_o    <= next_vld;
			echo_timing_output_o <= next_ph;
			write_ready_o        <= buf_ready;
			ecc_active_o         <= !next_off;
			dll_active_o         <= dll_n_s;
			ecc_off              <= next_off;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	a_read_beats: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_cmd |-> ##6 (read_valid_flag_o && read_data_oe_o) ##1 read_valid_flag_o)
		else $error("read beats not at 2.5 and 3 cycles");
	a_idle_slot: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(ph == ddr_sram_pkg::PH_K && rd_n_s) |-> ##6
		(!read_valid_flag_o && read_data_out_o == '0 && read_data_oe_o == $past(term_s)))
		else $error("idle slot output wrong");
	a_read_first: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_cmd |-> !drain)
		else $error("write drained over a read slot");
	a_write_push: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(ph == ddr_sram_pkg::PH_K && !wr_n_s) |=> (push_v && push_w[BW-1 -: ADDR_W] == addr_s))
		else $error("write not pushed with following address");
	a_write_none: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(ph == ddr_sram_pkg::PH_K && wr_n_s) |=> !push_v)
		else $error("deselect pushed a write");
	a_beat_mask: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(ph == ddr_sram_pkg::PH_K && !wr_n_s) ##1 1'b1 |->
		(push_w[2*DW +: LANES] == $past(bw_n_s) && push_w[DW-1:0] == $past(data_s)))
		else $error("beat mask or data paired wrongly");
	a_half_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		half_wr |=> (!ecc_active_o [*3]))
		else $error("correction left on after half write");
	a_ecc_sticky: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		$fell(ecc_active_o) |-> $past(half_wr))
		else $error("correction dropped without half write");
	a_dll_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!dll_disable_n_i ##1 !dll_disable_n_i [*3] |=> !dll_active_o)
		else $error("timing loop not off");

	c_read:  cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_cmd ##7 read_valid_flag_o);
	c_write: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) drain);
	c_half:  cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) half_wr);
	c_full:  cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) !buf_ready);
endmodule

// File: bench/ddr_ctrl_model.sv
`timescale 1ns/100ps
module ddr_ctrl_model #(
	parameter int ADDR_W   = 8,
	parameter int DATA_W   = 18,
	parameter int LANE_N   = 2,
	parameter int WAKE_CYC = 32
) (
	input  wire logic              clk_sys_i,   // System clock
	input  wire logic              sys_rst_i,   // Async reset
	output logic      [ADDR_W-1:0] addr_o,      // Shared address
	output logic                   rd_n_o,      // Read request, low
	output logic                   wr_n_o,      // Write request, low
	output logic      [DATA_W-1:0] data_o,      // Write data beats
	output logic      [LANE_N-1:0] lane_en_n_o  // Lane enables, low
);
	int edge_n;

	initial begin
		addr_o = '0;
		rd_n_o = 1'h1;
		wr_n_o = 1'h1;
		data_o = '0;
		lane_en_n_o = '1;
	end

	// Edge 0 is the first edge after release, a K half
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			edge_n <= -1;
		else
			edge_n <= edge_n + 1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Shortened power-up wait, the full count would dominate the run
	task automatic to_odd();
		do @(posedge clk_sys_i); while (edge_n[0] != 1'h0 || edge_n < WAKE_CYC);
	endtask

	// Pins set now are sampled at the next K edge, returned in c0
	task automatic issue(input logic rd, input logic wr, input logic [ADDR_W-1:0] ra,
			input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d0,
			input logic [DATA_W-1:0] d1, input logic [LANE_N-1:0] m0,
			input logic [LANE_N-1:0] m1, output int c0);
		to_odd();
		c0 = edge_n + 2;
		rd_n_o <= ~rd;
		wr_n_o <= ~wr;
		addr_o <= ra;
		data_o <= d0;
		lane_en_n_o <= m0;
		@(posedge clk_sys_i);
		rd_n_o <= 1'h1;
		wr_n_o <= 1'h1;
		addr_o <= wa;
		data_o <= d1;
		lane_en_n_o <= m1;
	endtask

	// Released lines toggle so stale values never look valid
	task automatic rest(input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			addr_o <= ~addr_o;
			data_o <= ~data_o;
			lane_en_n_o <= ~lane_en_n_o;
		end
	endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
	logic        clk_sys_i;
	logic        sys_rst_i;
	logic [7:0]  address_bus;
	logic        read_req_n;
	logic        write_req_n;
	logic [17:0] write_data;
	logic [1:0]  lane_en_n;
	logic        term_sel;
	logic        dll_dis_n;
	logic [17:0] read_data;
	logic        read_oe;
	logic        read_valid;
	logic        echo;
	logic        write_ready;
	logic        ecc_active;
	logic        dll_active;
	logic        saw_full;
	int          n_mismatch;
	int          comparisons;
	logic [35:0] mem [0:255];
	logic [17:0] q_data [$];
	int          q_edge [$];

	ddr_sram_port_ecc ddr_sram_port_ecc_i (
		.clk_sys_i             (clk_sys_i),
		.sys_rst_i             (sys_rst_i),
		.address_bus_i         (address_bus),
		.read_req_n_i          (read_req_n),
		.write_req_n_i         (write_req_n),
		.write_data_in_i       (write_data),
		.byte_lane_enables_n_i (lane_en_n),
		.termination_select_i  (term_sel),
		.dll_disable_n_i       (dll_dis_n),
		.read_data_out_o       (read_data),
		.read_data_oe_o        (read_oe),
		.read_valid_flag_o     (read_valid),
		.echo_timing_output_o  (echo),
		.write_ready_o         (write_ready),
		.ecc_active_o          (ecc_active),
		.dll_active_o          (dll_active)
	);

	ddr_ctrl_model ddr_ctrl_model_i (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.addr_o      (address_bus),
		.rd_n_o      (read_req_n),
		.wr_n_o      (write_req_n),
		.data_o      (write_data),
		.lane_en_n_o (lane_en_n)
	);

	initial begin
		clk_sys_i = 1'h0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// Beat capture tagged with the edge that set the output flop
	always @(posedge clk_sys_i) begin
		if (read_valid === 1'h1) begin
			q_data.push_back(read_data);
			q_edge.push_back(ddr_ctrl_model_i.edge_n);
		end
		if (write_ready === 1'h0)
			saw_full <= 1'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [35:0] b1(input logic v);
		return {35'h0, v};
	endfunction

	function automatic logic [35:0] merge(input logic [35:0] old, input logic [17:0] d0,
			input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
		logic [35:0] r;
		r = old;
		for (int l = 0; l < 2; l++) begin
			if (!m0[l])
				r[9*l +: 9] = d0[9*l +: 9];
			if (!m1[l])
				r[18+9*l +: 9] = d1[9*l +: 9];
		end
		return r;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [17:0] d0, input logic [17:0] d1,
			input logic [1:0] m0, input logic [1:0] m1);
		int c;
		ddr_ctrl_model_i.issue(1'h0, 1'h1, a, a, d0, d1, m0, m1, c);
		mem[a] = merge(mem[a], d0, d1, m0, m1);
	endtask

	task automatic expect_read(input logic [7:0] a, input int c0);
		if (q_data.size() < 2) begin
			chk("beat count", 36'h2, 36'(q_data.size()));
			complete_run();
		end
		chk("beat0 edge", 36'(c0 + 7), 36'(q_edge.pop_front()));
		chk("beat0", {18'h0, mem[a][17:0]}, {18'h0, q_data.pop_front()});
		chk("beat1 edge", 36'(c0 + 8), 36'(q_edge.pop_front()));
		chk("beat1", {18'h0, mem[a][35:18]}, {18'h0, q_data.pop_front()});
	endtask

	task automatic rd_pair(input logic [7:0] a, input logic [7:0] b);
		int          c0;
		int          c1;
		logic [17:0] junk;
		// Write side stays deselected, so whatever sits on its pins must not be stored
		junk = {a, b, a[1:0]};
		ddr_ctrl_model_i.issue(1'h1, 1'h0, a, b, junk, ~junk, a[1:0], b[1:0], c0);
		ddr_ctrl_model_i.issue(1'h1, 1'h0, b, a, ~junk, junk, b[1:0], a[1:0], c1);
		ddr_ctrl_model_i.rest(14);
		expect_read(a, c0);
		expect_read(b, c1);
	endtask

	// Bounded wait; running out ends the run
	task automatic wait_flag(input string what, ref logic sig, input logic val, input int lim);
		for (int i = 0; i < lim && sig !== val; i++)
			@(posedge clk_sys_i);
		chk(what, b1(val), b1(sig));
		if (sig !== val)
			complete_run();
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic s_reset();
		@(posedge clk_sys_i);
		#1;
		chk("ecc after reset", 36'h1, b1(ecc_active));
		chk("ready after reset", 36'h1, b1(write_ready));
		chk("valid after reset", 36'h0, b1(read_valid));
		chk("echo k-bar half", 36'h1, b1(echo));
		@(posedge clk_sys_i);
		#1;
		chk("echo k half", 36'h0, b1(echo));
	endtask

	task automatic s_dll();
		@(posedge clk_sys_i);
		dll_dis_n <= 1'h0;
		wait_flag("loop off", dll_active, 1'h0, 8);
		@(posedge clk_sys_i);
		dll_dis_n <= 1'h1;
		wait_flag("loop on", dll_active, 1'h1, 8);
	endtask

	task automatic s_write_read();
		wr(8'h11, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0);
		wr(8'h12, 18'h3c3c3, 18'h0f0f0, 2'h0, 2'h0);
		ddr_ctrl_model_i.rest(8);
		rd_pair(8'h11, 8'h12);
	endtask

	task automatic s_mask();
		wr(8'h20, 18'h15555, 18'h2aaaa, 2'h0, 2'h0);
		wr(8'h21, 18'h0ff00, 18'h300ff, 2'h0, 2'h0);
		wr(8'h20, 18'h3ffff, 18'h3ffff, 2'h2, 2'h2);
		wr(8'h21, 18'h00000, 18'h00000, 2'h1, 2'h1);
		ddr_ctrl_model_i.rest(8);
		rd_pair(8'h20, 8'h21);
		chk("ecc after abort", 36'h1, b1(ecc_active));
	endtask

	task automatic s_idle();
		for (int t = 0; t < 2; t++) begin
			@(posedge clk_sys_i);
			term_sel <= 1'(t);
			ddr_ctrl_model_i.rest(12);
			#1;
			chk("idle oe", b1(1'(t)), b1(read_oe));
			chk("idle data", 36'h0, {18'h0, read_data});
		end
	endtask

	// Reads in every slot stall draining, so the buffer must fill
	task automatic s_fill();
		int c;
		saw_full = 1'h0;
		for (int i = 0; i < 20; i++)
			ddr_ctrl_model_i.issue(1'h1, 1'h1, 8'h11, 8'h40 + 8'(i), 18'(i), 18'(~i),
					2'h0, 2'h0, c);
		mem[8'h40] = {18'h3ffff, 18'h00000};
		ddr_ctrl_model_i.rest(60);
		chk("buffer filled", 36'h1, b1(saw_full));
		chk("buffer drained", 36'h1, b1(write_ready));
		chk("reads served", 36'd40, 36'(q_data.size()));
		q_data.delete();
		q_edge.delete();
		rd_pair(8'h40, 8'h11);
	endtask

	task automatic s_half();
		wr(8'h30, 18'h12345, 18'h2abcd, 2'h0, 2'h0);
		ddr_ctrl_model_i.rest(6);
		chk("ecc before half", 36'h1, b1(ecc_active));
		wr(8'h30, 18'h3ffff, 18'h00000, 2'h2, 2'h3);
		wait_flag("ecc off", ecc_active, 1'h0, 20);
		wr(8'h31, 18'h01111, 18'h02222, 2'h0, 2'h0);
		ddr_ctrl_model_i.rest(6);
		chk("ecc stays off", 36'h0, b1(ecc_active));
		rd_pair(8'h30, 8'h31);
	endtask

	initial begin
		sys_rst_i = 1'h1;
		term_sel = 1'h0;
		dll_dis_n = 1'h1;
		saw_full = 1'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'h0;
		s_reset();
		s_dll();
		s_write_read();
		s_mask();
		s_idle();
		s_fill();
		s_half();
		complete_run();
	end
endmodule
